// File: rtl/acc_map.vh
// Register offsets, field positions and reset values of the comparator block.
// Assumes a Wishbone slave decoding byte offsets on a 32-bit data bus.
// Contract
// - Result is high while selected positive input exceeds selected negative.
// - Raw result passes a synchronizer, two clocks before readable.
// - Event flag sets when a result change matches the edge mode.
// - Interrupt request only while flag, enable and global enable are set; irq_out ignores all three and follows the status and mask bits.
// - Vector execution clears the event flag.
// - Writing one to flag clears it; zero leaves it.
// - Edge mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Disable bit 7 switches comparator power off, settable any time.
// - Bandgap select bit picks bandgap, else positive pin, as positive input.
// - Capture route bit feeds result to timer capture, else no connection.
// - Mux enable with converter off picks channel 0..7, else negative pin.
// - Converter mux unusable unless power reduce bit is zero.
// - Buffer-off bits disable pin digital buffer; port bit reads zero.
// - Converter enable bit tells whether converter is on.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
`define ACC_OFS_CTRL 8'h50
`define ACC_OFS_CONVB 8'h7B
`define ACC_OFS_PINDIS 8'h7F
`define ACC_OFS_ISTAT 8'h80
`define ACC_OFS_IMASK 8'h84
`define ACC_OFS_SYSCTL 8'h88
`define ACC_B_DISABLE 7
`define ACC_B_BANDGAP 6
`define ACC_B_RESULT 5
`define ACC_B_FLAG 4
`define ACC_B_IRQEN 3
`define ACC_B_CAPT 2
`define ACC_B_MUXEN 6
`define ACC_B_GIE 0
`define ACC_B_CONVEN 1
`define ACC_B_PRR 2
`define ACC_RST_CTRL 8'h00
`define ACC_RST_CONVB 8'h00
`define ACC_RST_PINDIS 8'h00
`define ACC_RST_SYSCTL 8'h04
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3
`endif

// File: rtl/acc_analog_comparator_control.v
// Control logic of the on-chip voltage comparator, with a Wishbone slave.
// Assumes analog levels arrive as digitised codes and pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_analog_comparator_control #(
  parameter LEVEL_W = 10
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  input wire [LEVEL_W-1:0] positive_input_pin_in,
  input wire [LEVEL_W-1:0] negative_input_pin_in,
  input wire [LEVEL_W-1:0] bandgap_level_in,
  input wire [8*LEVEL_W-1:0] converter_inputs_in,
  input wire [2:0] channel_select_in,
  input wire vector_ack_in,
  input wire pos_pin_digital_in,
  input wire neg_pin_digital_in,
  output reg pos_pin_port_bit_out,
  output reg neg_pin_port_bit_out,
  output reg pos_pin_buffer_off_out,
  output reg neg_pin_buffer_off_out,
  output reg comparator_power_on_out,
  output reg capture_input_out,
  output reg compare_irq_out,
  output reg irq_out
);
  reg [7:0] ctrl_r;
  reg [7:0] convb_r;
  reg [1:0] pindis_r;
  reg [2:0] sysctl_r;
  reg [1:0] istat_r;
  reg [1:0] imask_r;
  reg raw_r;
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  reg pos_s1_r;
  reg pos_s2_r;
  reg neg_s1_r;
  reg neg_s2_r;
  reg [LEVEL_W-1:0] pos_lvl;
  reg [LEVEL_W-1:0] neg_lvl;
  reg edge_hit;
  reg [31:0] rd_data;
  wire bus_req;
  wire wr_lane0;
  wire rd_stb;
  wire wr_flag_one;
  wire mux_usable;
  wire [1:0] mode;

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_lane0 = bus_req & wb_we_in & wb_sel_in[0];
  assign rd_stb = bus_req & ~wb_we_in;
  assign wr_flag_one = wr_lane0 && (wb_adr_in == `ACC_OFS_CTRL) &&
    wb_dat_in[`ACC_B_FLAG];
  assign mode = ctrl_r[1:0];
  // The converter mux is only reachable with power reduction off.
  assign mux_usable = convb_r[`ACC_B_MUXEN] & ~sysctl_r[`ACC_B_CONVEN] &
    ~sysctl_r[`ACC_B_PRR];

  always @*
  begin
    pos_lvl = ctrl_r[`ACC_B_BANDGAP] ? bandgap_level_in :
      positive_input_pin_in;
    neg_lvl = mux_usable ?
      converter_inputs_in[channel_select_in*LEVEL_W +: LEVEL_W] :
      negative_input_pin_in;
  end

  // Reserved mode 01 raises no edge events, so the flag and status bit 0 stay quiet.
  always @*
  begin
    case (mode)
      `ACC_MODE_TOGGLE: edge_hit = sync2_r ^ prev_r;
      `ACC_MODE_FALL: edge_hit = prev_r & ~sync2_r;
      `ACC_MODE_RISE: edge_hit = ~prev_r & sync2_r;
      default: edge_hit = 1'b0;
    endcase
  end

  always @*
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr_in)
      `ACC_OFS_CTRL: rd_data[7:0] = {ctrl_r[7:6], sync2_r, ctrl_r[4:0]};
      `ACC_OFS_CONVB: rd_data[7:0] = {1'b0, convb_r[6], 3'h0, convb_r[2:0]};
      `ACC_OFS_PINDIS: rd_data[1:0] = pindis_r;
      `ACC_OFS_ISTAT: rd_data[1:0] = istat_r;
      `ACC_OFS_IMASK: rd_data[1:0] = imask_r;
      `ACC_OFS_SYSCTL: rd_data[2:0] = sysctl_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_r <= `ACC_RST_CTRL;
      convb_r <= `ACC_RST_CONVB;
      pindis_r <= 2'h0;
      sysctl_r <= 3'h4;
      istat_r <= 2'h0;
      imask_r <= 2'h0;
      raw_r <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      pos_s1_r <= 1'b0;
      pos_s2_r <= 1'b0;
      neg_s1_r <= 1'b0;
      neg_s2_r <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      pos_pin_port_bit_out <= 1'b0;
      neg_pin_port_bit_out <= 1'b0;
      pos_pin_buffer_off_out <= 1'b0;
      neg_pin_buffer_off_out <= 1'b0;
      comparator_power_on_out <= 1'b0;
      capture_input_out <= 1'b0;
      compare_irq_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      wb_ack_out <= bus_req;
      if (rd_stb)
        wb_dat_out <= rd_data;
      // A disabled comparator holds its result low.
      raw_r <= ~ctrl_r[`ACC_B_DISABLE] && (pos_lvl > neg_lvl);
      sync1_r <= raw_r;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      // Flag: a new event wins over a clear in the same cycle.
      if (edge_hit)
        ctrl_r[`ACC_B_FLAG] <= 1'b1;
      else if (vector_ack_in || wr_flag_one)
        ctrl_r[`ACC_B_FLAG] <= 1'b0;
      if (wr_lane0)
      begin
        case (wb_adr_in)
          `ACC_OFS_CTRL:
          begin
            ctrl_r[7:6] <= wb_dat_in[7:6];
            ctrl_r[3:0] <= wb_dat_in[3:0];
          end
          `ACC_OFS_CONVB:
          begin
            convb_r[6] <= wb_dat_in[6];
            convb_r[2:0] <= wb_dat_in[2:0];
          end
          `ACC_OFS_PINDIS: pindis_r <= wb_dat_in[1:0];
          `ACC_OFS_IMASK: imask_r <= wb_dat_in[1:0];
          `ACC_OFS_SYSCTL: sysctl_r <= wb_dat_in[2:0];
          default: imask_r <= imask_r;
        endcase
      end
      // Status bit 0 is the edge event, bit 1 the result rising; read clears.
      istat_r[0] <= edge_hit | (istat_r[0] &
        ~(rd_stb && wb_adr_in == `ACC_OFS_ISTAT));
      istat_r[1] <= (~prev_r & sync2_r) | (istat_r[1] &
        ~(rd_stb && wb_adr_in == `ACC_OFS_ISTAT));
      irq_out <= |(istat_r & imask_r);
      compare_irq_out <= ctrl_r[`ACC_B_FLAG] & ctrl_r[`ACC_B_IRQEN] &
        sysctl_r[`ACC_B_GIE];
      capture_input_out <= ctrl_r[`ACC_B_CAPT] & sync2_r;
      comparator_power_on_out <= ~ctrl_r[`ACC_B_DISABLE];
      pos_s1_r <= pos_pin_digital_in;
      pos_s2_r <= pos_s1_r;
      neg_s1_r <= neg_pin_digital_in;
      neg_s2_r <= neg_s1_r;
      pos_pin_buffer_off_out <= pindis_r[0];
      neg_pin_buffer_off_out <= pindis_r[1];
      pos_pin_port_bit_out <= pos_s2_r & ~pindis_r[0];
      neg_pin_port_bit_out <= neg_s2_r & ~pindis_r[1];
    end
  end
endmodule
`default_nettype wire

// File: tb/acc_monitor.sv
// Assertions on the ports of the comparator control block.
// Assumes it is bound into that block and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module acc_monitor (
  input wire logic mclk_in, resetn_in, wb_cyc_in, wb_stb_in, wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out, vector_ack_in, compare_irq_out,
  input wire logic capture_input_out, comparator_power_on_out,
  input wire logic pos_pin_buffer_off_out, pos_pin_port_bit_out,
  input wire logic neg_pin_buffer_off_out, neg_pin_port_bit_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence ctl_wr;
    wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
      && wb_adr_in == 8'h50;
  endsequence
  chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("no ack");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  chk_flag_clear: assert property (ctl_wr ##0 wb_dat_in[4]
    |-> ##[1:3] !compare_irq_out) else $error("flag not cleared");
  chk_irq_gate: assert property (ctl_wr ##0 !wb_dat_in[3]
    |-> ##[1:3] !compare_irq_out) else $error("irq not gated");
  chk_power_off: assert property (ctl_wr ##0 wb_dat_in[7]
    |-> ##[1:3] !comparator_power_on_out) else $error("power stays on");
  chk_capture_off: assert property (ctl_wr ##0 !wb_dat_in[2]
    |-> ##[1:4] !capture_input_out) else $error("capture not cut");
  chk_vector_clear: assert property (vector_ack_in
    |-> ##[1:3] !compare_irq_out) else $error("vector kept flag");
  chk_buffer_zero: assert property (!(pos_pin_buffer_off_out
    && pos_pin_port_bit_out) && !(neg_pin_buffer_off_out
    && neg_pin_port_bit_out)) else $error("port bit not zero");
endmodule
bind acc_analog_comparator_control acc_monitor u_acc_monitor (.mclk_in,
  .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
  .wb_dat_in, .wb_ack_out, .vector_ack_in, .compare_irq_out,
  .capture_input_out, .comparator_power_on_out, .pos_pin_buffer_off_out,
  .pos_pin_port_bit_out, .neg_pin_buffer_off_out, .neg_pin_port_bit_out);
`default_nettype wire

// File: tb/acc_pins_model.sv
// Levels of the comparator pins and converter inputs.
// Assumes the bench steers the positive pin through pos_hi_in.
`timescale 1ns/1ps
`default_nettype none
module acc_pins_model (
  input wire logic pos_hi_in,
  output logic [9:0] pos_out, neg_out, gap_out,
  output logic [79:0] conv_out,
  output logic pos_dig_out, neg_dig_out
);
  // Channel k sits at 50 + 100k so every choice gives a known result.
  assign pos_out = pos_hi_in ? 10'h258 : 10'h0C8;
  assign neg_out = 10'h190;
  assign gap_out = 10'h1F4;
  assign conv_out = {10'h2EE, 10'h28A, 10'h226, 10'h1C2,
    10'h15E, 10'h0FA, 10'h096, 10'h032};
  assign pos_dig_out = pos_hi_in;
  assign neg_dig_out = !pos_hi_in;
endmodule
`default_nettype wire

// File: tb/acc_analog_comparator_control_tb_top.sv
// Self-checking bench of the comparator control block.
// Assumes the pin model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acc_analog_comparator_control_tb_top;
  logic mclk_in = 0, resetn_in = 0, wb_cyc_in = 0, wb_stb_in = 0, hi = 0;
  logic wb_we_in = 0, vector_ack_in = 0, wb_ack_out, irq_out;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rdat;
  logic [2:0] channel_select_in = 3'h0;
  logic [9:0] positive_input_pin_in, negative_input_pin_in, bandgap_level_in;
  logic [79:0] converter_inputs_in;
  logic pos_pin_digital_in, neg_pin_digital_in, pos_pin_port_bit_out;
  logic neg_pin_port_bit_out, pos_pin_buffer_off_out, neg_pin_buffer_off_out;
  logic comparator_power_on_out, capture_input_out, compare_irq_out;
  logic [7:0] sv [5] = '{8'h1, 8'h3, 8'h5, 8'h1, 8'h1};
  logic [2:0] cs [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
  logic ce [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int error_cnt = 0, compares = 0, cycles = 0;
  acc_analog_comparator_control u_acc_analog_comparator_control (.*);
  acc_pins_model u_acc_pins_model (.pos_hi_in(hi),
    .pos_out(positive_input_pin_in), .neg_out(negative_input_pin_in),
    .gap_out(bandgap_level_in), .conv_out(converter_inputs_in),
    .pos_dig_out(pos_pin_digital_in), .neg_dig_out(neg_pin_digital_in));
  initial forever #12.5 mclk_in = ~mclk_in;
  task automatic final_report;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
    rdat = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  initial
  begin
    wt(16);
    resetn_in <= 1'b1;
    wt(1);
    rc(8'h50, 32'h0);
    rc(8'h7B, 32'h0);
    rc(8'h7F, 32'h0);
    rc(8'h88, 32'h4);
    rc(8'h40, 32'h0);
    bus(1'b1, 8'h88, 32'h1);
    for (int m = 0; m < 4; m++)
      for (int d = 1; d >= 0; d--)
      begin
        bus(1'b1, 8'h50, {27'h0, 1'b1, 2'h0, m[1:0]});
        hi <= d[0];
        wt(8);
        rc(8'h50, {26'h0, d[0], m == 0 || (m > 1 && m[0] == d[0]),
          2'h0, m[1:0]});
      end
    bus(1'b1, 8'h84, 32'h1);
    bus(1'b1, 8'h50, 32'h10);
    bus(1'b1, 8'h50, 32'h18);
    bus(1'b0, 8'h80, 32'h0);
    hi <= 1'b1;
    wt(8);
    chk({compare_irq_out, irq_out}, 2'h3);
    vector_ack_in <= 1'b1;
    wt(1);
    vector_ack_in <= 1'b0;
    wt(3);
    chk(compare_irq_out, 1'b0);
    bus(1'b0, 8'h80, 32'h0);
    chk(rdat[1:0], 2'h3);
    wt(2);
    chk(irq_out, 1'b0);
    bus(1'b1, 8'h88, 32'h0);
    hi <= 1'b0;
    wt(8);
    chk(compare_irq_out, 1'b0);
    bus(1'b1, 8'h88, 32'h1);
    wt(3);
    chk(compare_irq_out, 1'b1);
    bus(1'b1, 8'h50, 32'h18);
    wt(3);
    chk(compare_irq_out, 1'b0);
    bus(1'b1, 8'h7B, 32'h40);
    bus(1'b1, 8'h50, 32'h04);
    foreach (sv[i])
    begin
      channel_select_in <= cs[i];
      bus(1'b1, 8'h88, {24'h0, sv[i]});
      wt(8);
      chk(capture_input_out, ce[i]);
    end
    bus(1'b1, 8'h7B, 32'h0);
    bus(1'b1, 8'h50, 32'h44);
    wt(8);
    chk(capture_input_out, 1'b1);
    bus(1'b1, 8'h50, 32'h40);
    wt(8);
    chk(capture_input_out, 1'b0);
    bus(1'b1, 8'h50, 32'hC4);
    wt(8);
    chk({comparator_power_on_out, capture_input_out}, 2'h0);
    chk(neg_pin_port_bit_out, 1'b1);
    bus(1'b1, 8'h7F, 32'h3);
    wt(3);
    chk({pos_pin_buffer_off_out, neg_pin_buffer_off_out,
      neg_pin_port_bit_out}, 3'h6);
    rc(8'h7F, 32'h3);
    final_report;
  end
endmodule
`default_nettype wire
